// ===== rtl/fpi_regs.vh
// Command codes, field values and timing counts of the power/id command block
`ifndef FPI_REGS_VH
`define FPI_REGS_VH

// Command codes handled or screened by the block
`define FPI_CMD_SLEEP 8'hb9
`define FPI_CMD_WAKE 8'hab
`define FPI_CMD_SID 8'h90
`define FPI_CMD_DID 8'h92
`define FPI_CMD_QID 8'h94
`define FPI_CMD_TBI 8'h9f
`define FPI_CMD_CRX 8'hff
`define FPI_CMD_UID 8'h4b
`define FPI_CMD_SUS_A 8'h75
`define FPI_CMD_SUS_B 8'hb0
`define FPI_CMD_WRSR 8'h01
`define FPI_CMD_SEC_ER 8'h44
`define FPI_CMD_SEC_PG 8'h42
`define FPI_CMD_ER_1K 8'h8b
`define FPI_CMD_ER_4K 8'h20
`define FPI_CMD_ER_32K 8'h52
`define FPI_CMD_ER_64K 8'hd8
`define FPI_CMD_ER_CA 8'hc7
`define FPI_CMD_ER_CB 8'h60
`define FPI_CMD_PP 8'h02
`define FPI_CMD_QPP 8'h32

// Field values
`define FPI_CMD_BITS 8'h08
`define FPI_CONT_TAG 4'ha
`define FPI_ADDR_DEV_FIRST 24'h000001

// Clocks after the command byte before data out, and address clocks
`define FPI_PRE_WAKE 8'h18
`define FPI_PRE_SID 8'h18
`define FPI_PRE_DID 8'h0c
`define FPI_PRE_QID 8'h0a
`define FPI_PRE_UID 8'h20
`define FPI_ADR_QID 8'h06
`define FPI_WAKE_ID_MIN 8'h20

// Delays in 20 MHz cycles: 3 us, 3 us and 8 us, sized for the timer
`define FPI_CYC_SLEEP 12'h03c
`define FPI_CYC_WAKE1 12'h03c
`define FPI_CYC_WAKE2 12'h0a0

`endif

// ===== rtl/fpi_sync2.v
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module fpi_sync2 #(
    parameter W = 6,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk_in, // System clock
    input wire resetn_in, // Asynchronous reset, active low
    input wire [W-1:0] d_in, // Asynchronous inputs
    output reg [W-1:0] q_out // Synchronised copy
);
    reg [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_reg <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // fpi_sync2

// ===== rtl/fpi_delay_timer.v
// Down counter that times one delay and pulses at its end
`timescale 1ns/1ps
module fpi_delay_timer #(
    parameter W = 12
) (
    input wire clk_in, // System clock
    input wire resetn_in, // Asynchronous reset, active low
    input wire load_in, // Start pulse
    input wire [W-1:0] count_in, // Cycles to wait, at least one
    output wire busy_out, // High while counting
    output reg done_out // One-cycle pulse at the end
);
    reg [W-1:0] cnt_reg;

    assign busy_out = (cnt_reg != {W{1'b0}});

    // A new load restarts the count
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg <= {W{1'b0}};
            done_out <= 1'b0;
        end else begin
            done_out <= (cnt_reg == {{(W-1){1'b0}}, 1'b1}) && !load_in;
            if (load_in) begin
                cnt_reg <= count_in;
            end else if (busy_out) begin
                cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // fpi_delay_timer

// ===== rtl/fpi_cmd_core.v
// Sleep, wake, identification, continuous-read exit and suspend commands
`timescale 1ns/1ps
`include "fpi_regs.vh"
module fpi_cmd_core #(
    parameter [7:0] MFR_ID = 8'h5a, // Arbitrary value
    parameter [7:0] DEV_ID = 8'h13, // Arbitrary value
    parameter [7:0] MEM_TYPE = 8'h40, // Arbitrary value
    parameter [7:0] CAPACITY = 8'h14, // Arbitrary value
    parameter [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
    input wire sys_clk_in, // System clock, 20 MHz
    input wire resetn_in, // Asynchronous reset, active low
    input wire spi_sclk_in, // Serial clock pin
    input wire spi_cs_n_in, // Chip select pin, active low
    input wire [3:0] spi_io_in, // Data pins, input side
    output reg [3:0] spi_io_out, // Data pins, output side
    output reg [3:0] spi_io_oe_out, // Data pin enables, high drives
    input wire write_in_progress_in, // Array cycle running
    input wire prog_active_in, // Page program running
    input wire erase_active_in, // Sector or block erase running
    input wire suspend_clear_in, // Resume or reset clears suspend
    input wire [7:0] cont_mode_byte_in, // Mode byte of a fast read
    input wire cont_mode_load_in, // Mode byte valid pulse
    output reg sleep_out, // Deep sleep state
    output reg suspend_flag_out, // Suspend flag
    output reg suspend_prog_out, // Suspended cycle was a program
    output reg suspend_req_out, // Pulse: engine must pause
    output reg cont_read_active_out, // Continuous-read mode active
    output reg xip_start_out, // Pulse: frame is a fast read
    output reg cmd_valid_out, // Pulse: other command for engine
    output reg [7:0] cmd_code_out, // Code of forwarded command
    output reg [1:0] status_out // {suspend flag, write in progress}
);
    wire [5:0] pin_s;
    reg sclk_d_reg;
    reg cs_d_reg;
    reg [7:0] cnt_reg;
    reg [7:0] cmd_reg;
    reg [23:0] addr_reg;
    reg [127:0] out_sr_reg;
    reg out_act_reg;
    reg rot_reg;
    reg [1:0] lanes_reg;
    reg frame_ok_reg;
    reg xip_frame_reg;
    reg sleep_pend_reg;
    reg wake_pend_reg;
    reg tmr_load_reg;
    reg [11:0] tmr_cnt_reg;
    wire tmr_busy;
    wire tmr_done;

    // Pins cross into the system clock domain first
    fpi_sync2 #(.W(6), .RST_VAL(6'h10)) u_sync (
        .clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .d_in({spi_sclk_in, spi_cs_n_in, spi_io_in}),
        .q_out(pin_s)
    );

    fpi_delay_timer #(.W(12)) u_tmr (
        .clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .load_in(tmr_load_reg),
        .count_in(tmr_cnt_reg),
        .busy_out(tmr_busy),
        .done_out(tmr_done)
    );

    // Edge finding on the synchronised clock and select
    wire sclk_s = pin_s[5];
    wire cs_s = pin_s[4];
    wire [3:0] io_s = pin_s[3:0];
    wire sclk_rise = sclk_s && !sclk_d_reg;
    wire sclk_fall = !sclk_s && sclk_d_reg;
    wire cs_rise = cs_s && !cs_d_reg;
    wire cs_fall = !cs_s && cs_d_reg;
    wire sel = !cs_s;
    wire [7:0] byte_next = {cmd_reg[6:0], io_s[0]};

    // Lane code: 0 single, 1 dual, 2 quad
    function [1:0] lane_of;
        input [7:0] c;
        begin
            if (c == `FPI_CMD_DID) begin
                lane_of = 2'd1;
            end else if (c == `FPI_CMD_QID) begin
                lane_of = 2'd2;
            end else begin
                lane_of = 2'd0;
            end
        end
    endfunction

    // Clocks between command byte and first output bit
    function [7:0] pre_of;
        input [7:0] c;
        begin
            if (c == `FPI_CMD_WAKE) begin
                pre_of = `FPI_PRE_WAKE;
            end else if (c == `FPI_CMD_SID) begin
                pre_of = `FPI_PRE_SID;
            end else if (c == `FPI_CMD_DID) begin
                pre_of = `FPI_PRE_DID;
            end else if (c == `FPI_CMD_QID) begin
                pre_of = `FPI_PRE_QID;
            end else if (c == `FPI_CMD_UID) begin
                pre_of = `FPI_PRE_UID;
            end else begin
                pre_of = 8'h00;
            end
        end
    endfunction

    // Commands that stream identification data
    function is_stream;
        input [7:0] c;
        begin
            is_stream = (c == `FPI_CMD_WAKE) || (c == `FPI_CMD_SID) ||
                (c == `FPI_CMD_DID) || (c == `FPI_CMD_QID) ||
                (c == `FPI_CMD_TBI) || (c == `FPI_CMD_UID);
        end
    endfunction

    // Commands consumed here and never forwarded
    function is_local;
        input [7:0] c;
        begin
            is_local = is_stream(c) || (c == `FPI_CMD_SLEEP) ||
                (c == `FPI_CMD_CRX) || (c == `FPI_CMD_SUS_A) ||
                (c == `FPI_CMD_SUS_B);
        end
    endfunction

    // Commands barred while a cycle is suspended; program codes only if the suspended cycle was a program
    function is_refused;
        input [7:0] c;
        input sus;
        input sus_prog;
        reg base;
        begin
            base = (c == `FPI_CMD_WRSR) || (c == `FPI_CMD_SEC_ER) ||
                (c == `FPI_CMD_ER_1K) || (c == `FPI_CMD_ER_4K) ||
                (c == `FPI_CMD_ER_32K) || (c == `FPI_CMD_ER_64K) ||
                (c == `FPI_CMD_ER_CA) || (c == `FPI_CMD_ER_CB);
            is_refused = sus && (base || (sus_prog &&
                ((c == `FPI_CMD_SEC_PG) || (c == `FPI_CMD_PP) ||
                (c == `FPI_CMD_QPP))));
        end
    endfunction

    // Stream commands allowed in the present state
    wire write_in_progress = write_in_progress_in;
    wire stream_ok = is_stream(byte_next) &&
        (!sleep_out || byte_next == `FPI_CMD_WAKE) &&
        !(write_in_progress && (byte_next == `FPI_CMD_WAKE)) &&
        !(write_in_progress && (byte_next == `FPI_CMD_TBI));
    reg cmd_ok_reg;

    // Address capture, only during the address clocks
    wire [7:0] adr_clks = (cmd_reg == `FPI_CMD_QID) ? `FPI_ADR_QID :
        pre_of(cmd_reg);
    wire in_addr = (cnt_reg >= `FPI_CMD_BITS) &&
        ({1'b0, cnt_reg} < ({1'b0, adr_clks} + 9'd8));
    reg [23:0] addr_next;
    always @* begin
        addr_next = addr_reg;
        if (in_addr) begin
            if (lanes_reg == 2'd2) begin
                addr_next = {addr_reg[19:0], io_s};
            end else if (lanes_reg == 2'd1) begin
                addr_next = {addr_reg[21:0], io_s[1:0]};
            end else begin
                addr_next = {addr_reg[22:0], io_s[0]};
            end
        end
    end

    // Output stream picked from command and address
    wire [7:0] ld_cmd = (cnt_reg == 8'h07) ? byte_next : cmd_reg;
    wire dev_first = (addr_next == `FPI_ADDR_DEV_FIRST);
    reg [127:0] stream_val;
    always @* begin
        if (ld_cmd == `FPI_CMD_TBI) begin
            stream_val = {MFR_ID, MEM_TYPE, CAPACITY, 104'h0};
        end else if (ld_cmd == `FPI_CMD_WAKE) begin
            stream_val = {16{DEV_ID}};
        end else if (ld_cmd == `FPI_CMD_UID) begin
            stream_val = UNIQUE_ID;
        end else if (dev_first) begin
            stream_val = {8{DEV_ID, MFR_ID}};
        end else begin
            stream_val = {8{MFR_ID, DEV_ID}};
        end
    end
    wire load_now = sclk_rise && sel && frame_ok_reg && !xip_frame_reg &&
        (((cnt_reg == 8'h07) && stream_ok && (pre_of(byte_next) == 8'h00))
        || ((cnt_reg >= `FPI_CMD_BITS) && cmd_ok_reg &&
        (({1'b0, cnt_reg} + 9'd1) == ({1'b0, pre_of(cmd_reg)} + 9'd8))));

    // Frame engine: capture on rise, drive on fall
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            cnt_reg <= 8'h00;
            cmd_reg <= 8'h00;
            addr_reg <= 24'h000000;
            out_sr_reg <= 128'h0;
            out_act_reg <= 1'b0;
            rot_reg <= 1'b0;
            lanes_reg <= 2'd0;
            cmd_ok_reg <= 1'b0;
            frame_ok_reg <= 1'b0;
            xip_frame_reg <= 1'b0;
            spi_io_out <= 4'h0;
            spi_io_oe_out <= 4'h0;
            cmd_valid_out <= 1'b0;
            cmd_code_out <= 8'h00;
            xip_start_out <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_s;
            cmd_valid_out <= 1'b0;
            xip_start_out <= 1'b0;
            if (cs_fall) begin
                // Delays in progress make the frame void
                cnt_reg <= 8'h00;
                frame_ok_reg <= !tmr_busy;
                xip_frame_reg <= cont_read_active_out;
                lanes_reg <= 2'd0;
                cmd_ok_reg <= 1'b0;
                out_act_reg <= 1'b0;
            end else if (cs_rise || !sel) begin
                out_act_reg <= 1'b0;
                spi_io_oe_out <= 4'h0;
            end else if (sclk_rise) begin
                if (cnt_reg != 8'hff) begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
                if (cnt_reg < `FPI_CMD_BITS) begin
                    cmd_reg <= byte_next;
                end
                addr_reg <= addr_next;
                if (xip_frame_reg && frame_ok_reg && cnt_reg == 8'h00) begin
                    xip_start_out <= 1'b1;
                end
                if (cnt_reg == 8'h07) begin
                    lanes_reg <= lane_of(byte_next);
                    cmd_ok_reg <= stream_ok;
                    // Standard decode is off in sleep and fast-read mode
                    if (frame_ok_reg && !xip_frame_reg && !sleep_out &&
                        !is_local(byte_next) &&
                        !is_refused(byte_next, suspend_flag_out,
                        suspend_prog_out)) begin
                        cmd_valid_out <= 1'b1;
                        cmd_code_out <= byte_next;
                    end
                end
                if (load_now) begin
                    out_sr_reg <= stream_val;
                    out_act_reg <= 1'b1;
                    rot_reg <= (ld_cmd != `FPI_CMD_TBI);
                end
            end else if (sclk_fall && out_act_reg) begin
                // Identifiers leave MSB first, repeating where allowed
                if (lanes_reg == 2'd2) begin
                    spi_io_out <= out_sr_reg[127:124];
                    spi_io_oe_out <= 4'hf;
                    out_sr_reg <= {out_sr_reg[123:0],
                        rot_reg ? out_sr_reg[127:124] : 4'h0};
                end else if (lanes_reg == 2'd1) begin
                    spi_io_out <= {2'b00, out_sr_reg[127:126]};
                    spi_io_oe_out <= 4'h3;
                    out_sr_reg <= {out_sr_reg[125:0],
                        rot_reg ? out_sr_reg[127:126] : 2'b00};
                end else begin
                    spi_io_out <= {2'b00, out_sr_reg[127], 1'b0};
                    spi_io_oe_out <= 4'h2;
                    out_sr_reg <= {out_sr_reg[126:0],
                        rot_reg ? out_sr_reg[127] : 1'b0};
                end
            end
        end
    end

    // End-of-frame actions, counts fixed only at select rise; continuous-read exit at the eighth clock rise
    wire frame_end = cs_rise && frame_ok_reg && !xip_frame_reg;
    wire do_sleep = frame_end && cmd_reg == `FPI_CMD_SLEEP &&
        cnt_reg == `FPI_CMD_BITS && !write_in_progress && !sleep_out;
    wire do_wake = frame_end && sleep_out && !write_in_progress &&
        cmd_reg == `FPI_CMD_WAKE;
    wire wake1 = do_wake && cnt_reg == `FPI_CMD_BITS;
    wire wake2 = do_wake && cnt_reg >= `FPI_WAKE_ID_MIN;
    wire sus_cmd = (cmd_reg == `FPI_CMD_SUS_A) ||
        (cmd_reg == `FPI_CMD_SUS_B);
    wire do_sus = frame_end && !sleep_out && sus_cmd &&
        cnt_reg == `FPI_CMD_BITS && !suspend_flag_out && write_in_progress &&
        (prog_active_in || erase_active_in);
    wire xip_exit = sclk_rise && sel && xip_frame_reg && frame_ok_reg &&
        cnt_reg == 8'h07 && byte_next == `FPI_CMD_CRX;

    // Power state, suspend flag and continuous-read mode
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sleep_out <= 1'b0;
            sleep_pend_reg <= 1'b0;
            wake_pend_reg <= 1'b0;
            tmr_load_reg <= 1'b0;
            tmr_cnt_reg <= 12'h000;
            suspend_flag_out <= 1'b0;
            suspend_prog_out <= 1'b0;
            suspend_req_out <= 1'b0;
            cont_read_active_out <= 1'b0;
            status_out <= 2'b00;
        end else begin
            tmr_load_reg <= 1'b0;
            suspend_req_out <= 1'b0;
            if (do_sleep) begin
                sleep_pend_reg <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_cnt_reg <= `FPI_CYC_SLEEP;
            end else if (wake1 || wake2) begin
                wake_pend_reg <= 1'b1;
                tmr_load_reg <= 1'b1;
                tmr_cnt_reg <= wake1 ? `FPI_CYC_WAKE1 : `FPI_CYC_WAKE2;
            end else if (tmr_done) begin
                if (sleep_pend_reg) begin
                    sleep_out <= 1'b1;
                end
                if (wake_pend_reg) begin
                    sleep_out <= 1'b0;
                end
                sleep_pend_reg <= 1'b0;
                wake_pend_reg <= 1'b0;
            end
            // A new suspend wins over a clear in the same cycle
            if (do_sus) begin
                suspend_flag_out <= 1'b1;
                suspend_prog_out <= prog_active_in;
                suspend_req_out <= 1'b1;
            end else if (suspend_clear_in) begin
                suspend_flag_out <= 1'b0;
            end
            if (cont_mode_load_in) begin
                cont_read_active_out <=
                    (cont_mode_byte_in[7:4] == `FPI_CONT_TAG);
            end else if (xip_exit) begin
                cont_read_active_out <= 1'b0;
            end
            status_out <= {suspend_flag_out, write_in_progress};
        end
    end
endmodule // fpi_cmd_core

// ===== sim/fpi_cmd_core_sva.sv
// Port checks for the power, id and suspend command block
`timescale 1ns/1ps
`include "fpi_regs.vh"
module fpi_cmd_core_sva (
    input wire sys_clk_in, // Clock
    input wire resetn_in, // Reset
    input wire spi_cs_n_in, // Select
    input wire [3:0] spi_io_oe_out, // Enables
    input wire write_in_progress_in, // Busy
    input wire [7:0] cont_mode_byte_in, // Mode byte
    input wire cont_mode_load_in, // Mode load
    input wire sleep_out, // Asleep
    input wire suspend_flag_out, // Suspended
    input wire suspend_req_out, // Pause pulse
    input wire cont_read_active_out, // Continuous read
    input wire cmd_valid_out, // Forward pulse
    input wire [7:0] cmd_code_out, // Forwarded code
    input wire [1:0] status_out // Status
);
    reg [15:0] hi_reg; // Cycles deselected
    // Cycles select has been high
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            hi_reg <= 16'h0000;
        else
            hi_reg <= spi_cs_n_in ? hi_reg + {15'h0, ~&hi_reg} : 16'h0000;
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_idle;
        spi_cs_n_in [*7];
    endsequence
    sequence s_pause;
        suspend_req_out ##1 !suspend_req_out;
    endsequence
    property p_oe_idle;
        s_idle |-> spi_io_oe_out == 4'h0;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("idle drive");
    property p_sleep_in;
        $rose(sleep_out) |-> hi_reg inside {[60:68]};
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep time");
    property p_wake;
        $fell(sleep_out) |-> hi_reg inside {[60:68], [160:168]};
    endproperty
    a_wake: assert property (p_wake) else $error("wake time");
    property p_mute;
        sleep_out |-> !cmd_valid_out && !suspend_req_out;
    endproperty
    a_mute: assert property (p_mute) else $error("acted asleep");
    property p_pause;
        suspend_req_out |-> s_pause ##0 suspend_flag_out;
    endproperty
    a_pause: assert property (p_pause) else $error("pause pulse");
    property p_sus_cause;
        $rose(suspend_flag_out) |-> $past(write_in_progress_in);
    endproperty
    a_sus_cause: assert property (p_sus_cause) else $error("idle held");
    property p_status;
        $past(resetn_in) |-> status_out[0] == $past(write_in_progress_in);
    endproperty
    a_status: assert property (p_status) else $error("busy bit");
    property p_cont_in;
        cont_mode_load_in && cont_mode_byte_in[7:4] == `FPI_CONT_TAG
            |-> ##[1:2] cont_read_active_out;
    endproperty
    a_cont_in: assert property (p_cont_in) else $error("no xip");
    property p_refuse;
        cmd_valid_out && suspend_flag_out |-> !(cmd_code_out inside
            {8'h01, 8'h44, 8'h8b, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60});
    endproperty
    a_refuse: assert property (p_refuse) else $error("held code");
endmodule // fpi_cmd_core_sva

bind fpi_cmd_core fpi_cmd_core_sva i_sva (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_io_oe_out(spi_io_oe_out),
    .write_in_progress_in(write_in_progress_in),
    .cont_mode_byte_in(cont_mode_byte_in),
    .cont_mode_load_in(cont_mode_load_in), .sleep_out(sleep_out),
    .suspend_flag_out(suspend_flag_out), .suspend_req_out(suspend_req_out),
    .cont_read_active_out(cont_read_active_out),
    .cmd_valid_out(cmd_valid_out), .cmd_code_out(cmd_code_out),
    .status_out(status_out));

// ===== sim/fpi_spi_host.sv
// Behavioural serial host that frames commands for the block
`timescale 1ns/1ps
module fpi_spi_host (
    input wire sys_clk_in, // Clock
    input wire [3:0] dev_io_in, // Resolved data lines
    input wire [3:0] dev_oe_in, // Device enables
    output reg spi_sclk_out = 1'b0, // Serial clock, still between frames
    output reg spi_cs_n_out = 1'b1, // Select, active low
    output reg [3:0] spi_io_out = 4'h5 // Host data lines
);
    reg drove = 1'b0; // Device drove a line this frame
    // One clock: data set while low, taken on the rise
    task bit1(input [3:0] d, input [3:0] m, output [3:0] q);
        spi_sclk_out <= 1'b0;
        spi_io_out <= (d & m) | (~spi_io_out & ~m); // Unused lines toggle
        repeat (4) @(posedge sys_clk_in);
        spi_sclk_out <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        q = dev_io_in;
        drove = drove | (|dev_oe_in);
    endtask
    // Command and address most significant first
    task frame(input [7:0] c, input int nc, input [47:0] a, input int na,
               input int aw, input int nr, input int rw,
               output [127:0] rd);
        reg [3:0] q;
        reg [3:0] m;
        spi_cs_n_out <= 1'b0;
        drove = 1'b0;
        rd = '0;
        repeat (4) @(posedge sys_clk_in);
        for (int i = 0; i < nc; i++)
            bit1({3'h0, c[7 - i % 8]}, 4'h1, q);
        m = (aw == 1) ? 4'h1 : (aw == 2) ? 4'h3 : 4'hf;
        for (int i = na - 1; i >= 0; i--)
            bit1(4'(a >> (i * aw)), m, q);
        m = (rw == 2) ? 4'h3 : 4'hf;
        for (int i = 0; i < nr; i++) begin
            bit1(4'h0, 4'h0, q);
            rd = (rd << rw) | ((rw == 1) ? {3'h0, q[1]} : q & m);
        end
        spi_sclk_out <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        spi_cs_n_out <= 1'b1; // Rise after the last clock, whole byte or not
        repeat (8) @(posedge sys_clk_in);
    endtask
endmodule // fpi_spi_host

// ===== sim/testbench.sv
// Self-checking bench for the power, id and suspend command block
`timescale 1ns/1ps
`include "fpi_regs.vh"
module testbench;
    localparam [7:0] MFR = 8'hc3; // Arbitrary value
    localparam [7:0] DEV = 8'h2e; // Arbitrary value
    localparam [7:0] MTY = 8'h61; // Arbitrary value
    localparam [7:0] CAP = 8'h15; // Arbitrary value
    localparam [127:0] UID = 128'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg write_in_progress = 1'b0, prog = 1'b0, erase = 1'b0, sus_clr = 1'b0;
    reg [7:0] mode_byte = 8'h00;
    reg mode_load = 1'b0;
    reg [7:0] held [0:10] = '{8'h01, 8'h44, 8'h8b, 8'h20, 8'h52, 8'hd8,
                               8'hc7, 8'h60, 8'h42, 8'h02, 8'h32};
    wire sclk, cs_n, sleep, sflag, sprog, sreq, cont, xip, cval;
    wire [3:0] h_io, d_io, d_oe;
    wire [3:0] io_w = (d_oe & d_io) | (~d_oe & h_io);
    wire [7:0] code;
    wire [1:0] status;
    int num_errors = 0, num_checks = 0, cyc = 0, nval = 0, nxip = 0, nreq = 0;
    reg [127:0] rd;
    fpi_cmd_core #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MTY),
        .CAPACITY(CAP), .UNIQUE_ID(UID)) i_dut (
        .sys_clk_in(clk), .resetn_in(rst_n), .spi_sclk_in(sclk),
        .spi_cs_n_in(cs_n), .spi_io_in(io_w), .spi_io_out(d_io),
        .spi_io_oe_out(d_oe), .write_in_progress_in(write_in_progress),
        .prog_active_in(prog), .erase_active_in(erase),
        .suspend_clear_in(sus_clr), .cont_mode_byte_in(mode_byte),
        .cont_mode_load_in(mode_load), .sleep_out(sleep),
        .suspend_flag_out(sflag), .suspend_prog_out(sprog),
        .suspend_req_out(sreq), .cont_read_active_out(cont),
        .xip_start_out(xip), .cmd_valid_out(cval), .cmd_code_out(code),
        .status_out(status));
    fpi_spi_host i_host (.sys_clk_in(clk), .dev_io_in(io_w),
        .dev_oe_in(d_oe), .spi_sclk_out(sclk), .spi_cs_n_out(cs_n),
        .spi_io_out(h_io));
    // 20 MHz clock
    initial forever #25 clk = ~clk;
    // Pulse counters; the limit cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        nval <= nval + (cval === 1'b1);
        nxip <= nxip + (xip === 1'b1);
        nreq <= nreq + (sreq === 1'b1);
        if (cyc == 40000) begin
            num_errors++;
            final_report;
        end
    end
    task check(input [127:0] seen, input [127:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task final_report;
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task cmd(input [7:0] c, input int nr = 0, input int na = 0);
        i_host.frame(c, 8, 48'h0, na, 1, nr, 1, rd);
    endtask
    task mode(input [7:0] b);
        mode_byte <= b;
        mode_load <= 1'b1;
        idle(1);
        mode_load <= 1'b0;
        idle(3);
    endtask
    // Main sequence
    initial begin
        int n;
        int w;
        idle(8);
        rst_n <= 1'b1;
        idle(6);
        check({sleep, sflag, cont, d_oe, status}, 0, "reset");
        cmd(`FPI_CMD_TBI, 24);
        check(rd, {MFR, MTY, CAP}, "tbi");
        cmd(`FPI_CMD_TBI, 4);
        cmd(`FPI_CMD_TBI, 8);
        check(rd, MFR, "tbi after cut");
        for (int k = 0; k < 6; k++) begin
            w = (k < 2) ? 1 : (k < 4) ? 2 : 4;
            i_host.frame(8'h90 + 8'(k / 2 * 2), 8, (k < 4) ? k % 2 :
                {23'h0, k[0], 16'h0}, (k < 4) ? 24 / w : 10, w, 16 / w, w, rd);
            check(rd, k[0] ? {DEV, MFR} : {MFR, DEV}, "id");
        end
        $display("Test id reads done");
        cmd(`FPI_CMD_WAKE, 24, 24);
        check(rd, {DEV, DEV, DEV}, "dev id");
        cmd(`FPI_CMD_UID, 128, 32);
        check(rd, UID, "uid");
        i_host.frame(`FPI_CMD_SLEEP, 9, 48'h0, 0, 1, 0, 1, rd);
        idle(100);
        check(sleep, 1'b0, "nine bits");
        write_in_progress <= 1'b1;
        cmd(`FPI_CMD_SLEEP);
        idle(100);
        check(sleep, 1'b0, "sleep busy");
        write_in_progress <= 1'b0;
        cmd(`FPI_CMD_SLEEP);
        idle(40);
        check(sleep, 1'b0, "sleep early");
        idle(40);
        check(sleep, 1'b1, "asleep");
        n = nval;
        cmd(`FPI_CMD_PP);
        cmd(`FPI_CMD_TBI, 8);
        check({nval - n, i_host.drove}, 0, "asleep quiet");
        write_in_progress <= 1'b1;
        cmd(`FPI_CMD_WAKE);
        idle(100);
        check(sleep, 1'b1, "wake busy");
        write_in_progress <= 1'b0;
        cmd(`FPI_CMD_WAKE);
        idle(40);
        check(sleep, 1'b1, "wake early");
        idle(40);
        check(sleep, 1'b0, "woken");
        cmd(`FPI_CMD_SLEEP);
        idle(80);
        cmd(`FPI_CMD_WAKE, 8, 24);
        idle(120);
        check(sleep, 1'b1, "long wake early");
        idle(60);
        check(sleep, 1'b0, "long wake");
        $display("Test sleep done");
        n = nreq;
        cmd(`FPI_CMD_SUS_A);
        check({sflag, nreq - n}, 0, "suspend idle");
        {write_in_progress, prog} <= 2'b11;
        cmd(`FPI_CMD_SUS_A);
        check({sflag, sprog, status[1], nreq - n}, {3'h7, 32'h1}, "pgm");
        write_in_progress <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            if (s == 1) begin
                sus_clr <= 1'b1;
                idle(1);
                {sus_clr, write_in_progress, prog, erase} <= 4'b0101;
                cmd(`FPI_CMD_SUS_B);
                check({sflag, sprog}, 2'b10, "erase held");
                n = nreq;
                cmd(`FPI_CMD_SUS_A);
                check(nreq - n, 0, "twice");
                write_in_progress <= 1'b0;
            end
            for (int k = 0; k < 11; k++) begin
                n = nval;
                cmd(held[k]);
                check(nval - n, s == 1 && k > 7, "held code");
            end
        end
        sus_clr <= 1'b1;
        idle(1);
        sus_clr <= 1'b0;
        $display("Test suspend done");
        mode(8'h5a);
        check(cont, 1'b0, "mode other");
        mode(8'ha7);
        check(cont, 1'b1, "mode tag");
        n = nxip;
        cmd(`FPI_CMD_TBI, 8);
        check({nxip - n, i_host.drove}, 2, "xip frame");
        cmd(`FPI_CMD_CRX);
        check(cont, 1'b0, "exit");
        $display("Test continuous read done");
        final_report;
    end
endmodule // testbench
